//--- tag_state_ctrl.sv
// operating-state controller: activation, heartbeat, pairing, monitoring
`timescale 1ns/1ps
module tag_state_ctrl #(
  parameter int TICK_CYCLES        = tag_monitor_pkg::TICK_CYCLES,
  parameter int PAIR_TIMEOUT_TICKS = tag_monitor_pkg::PAIR_TIMEOUT_MS
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // button pin and wake counter
  input  wire logic        i_button_n,
  input  wire logic        i_wake_expired,
  output logic [15:0]      o_interval,
  output logic             o_asleep,
  // association and activation
  output logic             o_assoc_req,
  input  wire logic        i_assoc_done,
  input  wire logic        i_activate_done,
  // radio messages
  output logic             o_msg_valid,
  input  wire logic        i_msg_ready,
  output logic [2:0]       o_msg_type,
  output logic [15:0]      o_msg_data,
  output logic             o_rx_open,
  input  wire logic        i_gw_status_req,
  input  wire logic        i_gw_prog_valid,
  input  wire logic [15:0] i_gw_prog_data,
  input  wire logic        i_gw_done,
  // tag reader
  output logic             o_rfid_start,
  output logic [7:0]       o_rfid_page,
  input  wire logic        i_tag_valid,
  input  wire logic [31:0] i_tag_page_a,
  input  wire logic [31:0] i_tag_page_b,
  output logic [63:0]      o_tag_id,
  // load cells
  output logic             o_adc_start,
  output logic [1:0]       o_adc_chan,
  input  wire logic        i_adc_valid,
  input  wire logic        i_adc_error,
  input  wire logic [15:0] i_adc_data,
  output logic [15:0]      o_weight,
  // battery sensing
  output logic             o_batt_start,
  input  wire logic        i_batt_valid,
  input  wire logic [7:0]  i_batt_level,
  output logic [7:0]       o_batt_level,
  // indicator and switched supplies
  output logic             o_led,
  output logic             o_radio_pwr,
  output logic             o_rfid_pwr,
  output logic             o_adc_pwr,
  output logic             o_batt_pwr
);

  tag_monitor_pkg::state_type state_r, state_nxt;
  tag_monitor_pkg::mode_type  mode_r, mode_nxt;
  logic [31:0] div_r, div_nxt, ms_r, ms_nxt;
  logic        tick_r, tick_nxt, press;
  logic        assoc_ok_r, assoc_ok_nxt, act_ok_r, act_ok_nxt;
  logic        pair_req_r, pair_req_nxt, mon_hb_r, mon_hb_nxt;
  logic        have_last_r, have_last_nxt, err_r, err_nxt, led_r, led_nxt;
  logic [7:0]  same_r, same_nxt, batt_r, batt_nxt;
  logic [2:0]  blink_r, blink_nxt, type_r, type_nxt;
  logic [1:0]  chan_r, chan_nxt;
  logic [17:0] sum_r, sum_nxt;
  logic [15:0] last_r, last_nxt, weight_r, weight_nxt, data_r, data_nxt;
  logic [15:0] interval_r, interval_nxt, w_new;
  logic [63:0] tag_r, tag_nxt;
  logic        batt_go_r, batt_go_nxt, adc_go_r, adc_go_nxt, rfid_go_r, rfid_go_nxt;

  // total of the four cells, clamped clear of the error code
  function automatic logic [15:0] settle_weight(input logic [17:0] sum, input logic err);
    if (err) begin
      settle_weight = tag_monitor_pkg::WEIGHT_ERROR;
    end else if (sum > {2'b00, tag_monitor_pkg::WEIGHT_MAX}) begin
      settle_weight = tag_monitor_pkg::WEIGHT_MAX;
    end else begin
      settle_weight = sum[15:0];
    end
  endfunction

  button_debounce u_debounce (
    .i_clock    (i_clock),
    .i_nrst     (i_nrst),
    .i_tick     (tick_r),
    .i_button_n (i_button_n),
    .o_press    (press)
  );

  // final weight as the last cell answers
  assign w_new = settle_weight(sum_r + {2'b00, i_adc_data}, err_r | i_adc_error);

  // millisecond enable divider
  always_comb begin
    tick_nxt = 1'b0;
    div_nxt  = div_r + 32'h00000001;
    if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_nxt  = 32'h00000000;
      tick_nxt = 1'b1;
    end
  end

  // sequencing of all operating states
  always_comb begin
    state_nxt     = state_r;
    mode_nxt      = mode_r;
    ms_nxt        = ms_r;
    assoc_ok_nxt  = assoc_ok_r | i_assoc_done;
    act_ok_nxt    = act_ok_r | i_activate_done;
    pair_req_nxt  = pair_req_r;
    mon_hb_nxt    = mon_hb_r;
    have_last_nxt = have_last_r;
    err_nxt       = err_r;
    led_nxt       = led_r;
    same_nxt      = same_r;
    batt_nxt      = batt_r;
    blink_nxt     = blink_r;
    type_nxt      = type_r;
    data_nxt      = data_r;
    chan_nxt      = chan_r;
    sum_nxt       = sum_r;
    last_nxt      = last_r;
    weight_nxt    = weight_r;
    interval_nxt  = interval_r;
    tag_nxt       = tag_r;
    batt_go_nxt   = 1'b0;
    adc_go_nxt    = 1'b0;
    rfid_go_nxt   = 1'b0;
    unique case (state_r)
      tag_monitor_pkg::ST_ASSOC: begin
        if (assoc_ok_nxt && act_ok_nxt) begin
          state_nxt = tag_monitor_pkg::ST_SLEEP;
        end
      end
      tag_monitor_pkg::ST_SLEEP: begin
        if (press) begin
          state_nxt    = tag_monitor_pkg::ST_BATT;
          pair_req_nxt = 1'b1;
          batt_go_nxt  = 1'b1;
        end else if (i_wake_expired) begin
          state_nxt    = tag_monitor_pkg::ST_BATT;
          pair_req_nxt = 1'b0;
          batt_go_nxt  = 1'b1;
        end
      end
      tag_monitor_pkg::ST_BATT: begin
        if (i_batt_valid) begin
          batt_nxt = i_batt_level;
          if (pair_req_r) begin
            pair_req_nxt = 1'b0;
            if (i_batt_level < tag_monitor_pkg::LOW_BATT_LEVEL) begin
              state_nxt = tag_monitor_pkg::ST_SLEEP;
              led_nxt   = 1'b0;
            end else begin
              state_nxt   = tag_monitor_pkg::ST_PAIR;
              led_nxt     = 1'b1;
              rfid_go_nxt = 1'b1;
              ms_nxt      = 32'h00000000;
            end
          end else if (mode_r == tag_monitor_pkg::MODE_HEART) begin
            state_nxt = tag_monitor_pkg::ST_SEND;
            type_nxt  = tag_monitor_pkg::MSG_HEARTBEAT;
            data_nxt  = {8'h00, i_batt_level};
          end else begin
            state_nxt  = tag_monitor_pkg::ST_MEAS;
            chan_nxt   = 2'h0;
            sum_nxt    = 18'h00000;
            err_nxt    = 1'b0;
            adc_go_nxt = 1'b1;
          end
        end
      end
      tag_monitor_pkg::ST_MEAS: begin
        if (i_adc_valid) begin
          sum_nxt = sum_r + {2'b00, i_adc_data};
          err_nxt = err_r | i_adc_error;
          if (chan_r != tag_monitor_pkg::LAST_CELL) begin
            chan_nxt   = chan_r + 2'h1;
            adc_go_nxt = 1'b1;
          end else begin
            weight_nxt    = w_new;
            last_nxt      = w_new;
            have_last_nxt = 1'b1;
            state_nxt     = tag_monitor_pkg::ST_SEND;
            type_nxt      = tag_monitor_pkg::MSG_FULLNESS;
            data_nxt      = w_new;
            if (w_new == tag_monitor_pkg::EMPTY_WEIGHT) begin
              type_nxt   = tag_monitor_pkg::MSG_EMPTY;
              mode_nxt   = tag_monitor_pkg::MODE_HEART;
              mon_hb_nxt = 1'b0;
              same_nxt   = 8'h00;
            end else if (have_last_r && w_new == last_r) begin
              same_nxt = (same_r == 8'hFF) ? same_r : same_r + 8'h01;
              if (mon_hb_r) begin
                state_nxt = tag_monitor_pkg::ST_SLEEP;
              end else if (same_nxt >= tag_monitor_pkg::UNCHANGED_READINGS) begin
                type_nxt   = tag_monitor_pkg::MSG_MON_HB;
                mon_hb_nxt = 1'b1;
              end
            end else begin
              same_nxt   = 8'h00;
              mon_hb_nxt = 1'b0;
            end
          end
        end
      end
      tag_monitor_pkg::ST_SEND: begin
        if (i_msg_ready) begin
          state_nxt = tag_monitor_pkg::ST_RXWIN;
        end
      end
      tag_monitor_pkg::ST_RXWIN: begin
        if (i_gw_prog_valid) begin
          interval_nxt = i_gw_prog_data;
        end
        if (i_gw_status_req) begin
          state_nxt = tag_monitor_pkg::ST_SEND;
          type_nxt  = tag_monitor_pkg::MSG_STATUS;
          data_nxt  = {8'h00, batt_r};
        end else if (i_gw_done) begin
          state_nxt = tag_monitor_pkg::ST_SLEEP;
        end
      end
      tag_monitor_pkg::ST_PAIR: begin
        if (i_tag_valid) begin
          tag_nxt       = {i_tag_page_a, i_tag_page_b};
          mode_nxt      = tag_monitor_pkg::MODE_MON;
          mon_hb_nxt    = 1'b0;
          same_nxt      = 8'h00;
          have_last_nxt = 1'b0;
          led_nxt       = 1'b0;
          blink_nxt     = 3'h0;
          ms_nxt        = 32'h00000000;
          state_nxt     = tag_monitor_pkg::ST_BLINK;
        end else if (tick_r) begin
          if (ms_r == 32'(PAIR_TIMEOUT_TICKS - 1)) begin
            led_nxt   = 1'b0;
            state_nxt = tag_monitor_pkg::ST_SLEEP;
          end else begin
            ms_nxt = ms_r + 32'h00000001;
          end
        end
      end
      tag_monitor_pkg::ST_BLINK: begin
        if (tick_r) begin
          if (ms_r == 32'(tag_monitor_pkg::BLINK_HALF_MS - 1)) begin
            ms_nxt    = 32'h00000000;
            led_nxt   = ~led_r;
            blink_nxt = blink_r + 3'h1;
            if (blink_nxt == tag_monitor_pkg::BLINK_TOGGLES) begin
              state_nxt = tag_monitor_pkg::ST_SLEEP;
            end
          end else begin
            ms_nxt = ms_r + 32'h00000001;
          end
        end
      end
      default: state_nxt = tag_monitor_pkg::ST_ASSOC; // illegal code recovers to activation
    endcase
  end

  // state registers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r     <= tag_monitor_pkg::ST_ASSOC;
      mode_r      <= tag_monitor_pkg::MODE_HEART;
      div_r       <= 32'h00000000;
      ms_r        <= 32'h00000000;
      tick_r      <= 1'b0;
      assoc_ok_r  <= 1'b0;
      act_ok_r    <= 1'b0;
      pair_req_r  <= 1'b0;
      mon_hb_r    <= 1'b0;
      have_last_r <= 1'b0;
      err_r       <= 1'b0;
      led_r       <= 1'b0;
      same_r      <= 8'h00;
      batt_r      <= tag_monitor_pkg::BATT_RESET;
      blink_r     <= 3'h0;
      type_r      <= tag_monitor_pkg::MSG_HEARTBEAT;
      data_r      <= 16'h0000;
      chan_r      <= 2'h0;
      sum_r       <= 18'h00000;
      last_r      <= tag_monitor_pkg::WEIGHT_RESET;
      weight_r    <= tag_monitor_pkg::WEIGHT_RESET;
      interval_r  <= tag_monitor_pkg::INTERVAL_RESET;
      tag_r       <= tag_monitor_pkg::TAG_RESET;
      batt_go_r   <= 1'b0;
      adc_go_r    <= 1'b0;
      rfid_go_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      mode_r      <= mode_nxt;
      div_r       <= div_nxt;
      ms_r        <= ms_nxt;
      tick_r      <= tick_nxt;
      assoc_ok_r  <= assoc_ok_nxt;
      act_ok_r    <= act_ok_nxt;
      pair_req_r  <= pair_req_nxt;
      mon_hb_r    <= mon_hb_nxt;
      have_last_r <= have_last_nxt;
      err_r       <= err_nxt;
      led_r       <= led_nxt;
      same_r      <= same_nxt;
      batt_r      <= batt_nxt;
      blink_r     <= blink_nxt;
      type_r      <= type_nxt;
      data_r      <= data_nxt;
      chan_r      <= chan_nxt;
      sum_r       <= sum_nxt;
      last_r      <= last_nxt;
      weight_r    <= weight_nxt;
      interval_r  <= interval_nxt;
      tag_r       <= tag_nxt;
      batt_go_r   <= batt_go_nxt;
      adc_go_r    <= adc_go_nxt;
      rfid_go_r   <= rfid_go_nxt;
    end
  end

  // supplies follow the state that needs them
  assign o_radio_pwr = (state_r == tag_monitor_pkg::ST_ASSOC) | o_msg_valid | o_rx_open;
  assign o_rfid_pwr  = (state_r == tag_monitor_pkg::ST_PAIR);
  assign o_adc_pwr   = (state_r == tag_monitor_pkg::ST_MEAS);
  assign o_batt_pwr  = (state_r == tag_monitor_pkg::ST_BATT);

  // handshakes and registered data
  assign o_assoc_req  = (state_r == tag_monitor_pkg::ST_ASSOC);
  assign o_asleep     = (state_r == tag_monitor_pkg::ST_SLEEP);
  assign o_msg_valid  = (state_r == tag_monitor_pkg::ST_SEND);
  assign o_rx_open    = (state_r == tag_monitor_pkg::ST_RXWIN);
  assign o_msg_type   = type_r;
  assign o_msg_data   = data_r;
  assign o_rfid_start = rfid_go_r;
  assign o_rfid_page  = tag_monitor_pkg::TAG_PAGE_FIRST;
  assign o_tag_id     = tag_r;
  assign o_adc_start  = adc_go_r;
  assign o_adc_chan   = chan_r;
  assign o_weight     = weight_r;
  assign o_batt_start = batt_go_r;
  assign o_batt_level = batt_r;
  assign o_led        = led_r;
  assign o_interval   = interval_r;

  // checks
  chk_assoc_only: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == tag_monitor_pkg::ST_ASSOC) |-> (!o_rfid_pwr && !o_adc_pwr && !o_msg_valid))
    else $error("peripheral active before activation");
  chk_sleep_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_asleep && !press && !i_wake_expired) |=> o_asleep)
    else $error("woke without cause");
  chk_hb_message: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_batt_pwr && i_batt_valid && !pair_req_r && mode_r == tag_monitor_pkg::MODE_HEART)
    |=> (o_msg_valid && o_msg_type == tag_monitor_pkg::MSG_HEARTBEAT))
    else $error("no heartbeat status after wake");
  chk_pair_entry: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_batt_pwr && i_batt_valid && pair_req_r && i_batt_level >= tag_monitor_pkg::LOW_BATT_LEVEL)
    |=> (o_rfid_pwr && o_led && o_rfid_start))
    else $error("pairing not entered");
  chk_low_dark: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_batt_pwr && i_batt_valid && pair_req_r && i_batt_level < tag_monitor_pkg::LOW_BATT_LEVEL)
    |=> (o_asleep && !o_led) [*2])
    else $error("indicator lit on low battery");
  chk_tag_store: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_rfid_pwr && i_tag_valid) |=> (o_tag_id == {$past(i_tag_page_a), $past(i_tag_page_b)}
    && mode_r == tag_monitor_pkg::MODE_MON && !o_led))
    else $error("tag not captured");
  chk_fail_keep: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_rfid_pwr && !i_tag_valid) |=> ($stable(o_tag_id) && $stable(mode_r)))
    else $error("pairing data changed without a tag");
  chk_error_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_adc_pwr && i_adc_valid && (i_adc_error || err_r)
    && o_adc_chan == tag_monitor_pkg::LAST_CELL)
    |=> (o_weight == tag_monitor_pkg::WEIGHT_ERROR))
    else $error("error code not reported");
  chk_suppress: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_adc_pwr && i_adc_valid && o_adc_chan == tag_monitor_pkg::LAST_CELL && mon_hb_r
    && have_last_r && w_new == last_r && w_new != tag_monitor_pkg::EMPTY_WEIGHT) |=> o_asleep)
    else $error("report not suppressed");
  chk_empty_stop: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_adc_pwr && i_adc_valid && o_adc_chan == tag_monitor_pkg::LAST_CELL
    && w_new == tag_monitor_pkg::EMPTY_WEIGHT)
    |=> (mode_r == tag_monitor_pkg::MODE_HEART && o_msg_type == tag_monitor_pkg::MSG_EMPTY))
    else $error("empty not announced");

  cov_heartbeat: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_msg_valid && i_msg_ready && o_msg_type == tag_monitor_pkg::MSG_HEARTBEAT);
  cov_pair_ok: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_rfid_pwr && i_tag_valid);
  cov_mon_hb: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_msg_valid && o_msg_type == tag_monitor_pkg::MSG_MON_HB);
  cov_status: cover property (@(posedge i_clock) disable iff (!i_nrst)
    o_msg_valid && i_msg_ready && o_msg_type == tag_monitor_pkg::MSG_STATUS);

endmodule

//--- tag_monitor_pkg.sv
// constants, types and message codes shared by the tag state controller
package tag_monitor_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS  = 5;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // times counted in millisecond ticks, and the number of blink toggles
  localparam int PAIR_TIMEOUT_MS = 30000;
  localparam int BLINK_HALF_MS   = 100;
  localparam int DEBOUNCE_MS     = 10;
  localparam logic [2:0] BLINK_TOGGLES = 3'h4;

  // monitoring thresholds
  localparam logic [7:0]  UNCHANGED_READINGS = 8'h08;
  localparam logic [7:0]  LOW_BATT_LEVEL     = 8'h40;
  localparam logic [15:0] EMPTY_WEIGHT       = 16'h0000;
  localparam logic [15:0] WEIGHT_ERROR       = 16'hFC00;
  localparam logic [15:0] WEIGHT_MAX         = 16'hFBFF;
  localparam logic [1:0]  LAST_CELL          = 2'h3;

  // tag pages that carry the stored value
  localparam logic [7:0] TAG_PAGE_FIRST = 8'h04;
  localparam logic [7:0] TAG_PAGE_SECOND = 8'h05;

  // reset values
  localparam logic [63:0] TAG_RESET      = 64'h0000000000000000;
  localparam logic [15:0] INTERVAL_RESET = 16'h003C;
  localparam logic [15:0] WEIGHT_RESET   = 16'h0000;
  localparam logic [7:0]  BATT_RESET     = 8'h00;

  // outgoing message codes
  localparam logic [2:0] MSG_HEARTBEAT = 3'h1;
  localparam logic [2:0] MSG_FULLNESS  = 3'h2;
  localparam logic [2:0] MSG_MON_HB    = 3'h3;
  localparam logic [2:0] MSG_EMPTY     = 3'h4;
  localparam logic [2:0] MSG_STATUS    = 3'h5;

  typedef enum logic [7:0] {
    ST_ASSOC = 8'h01,
    ST_SLEEP = 8'h02,
    ST_BATT  = 8'h04,
    ST_MEAS  = 8'h08,
    ST_SEND  = 8'h10,
    ST_RXWIN = 8'h20,
    ST_PAIR  = 8'h40,
    ST_BLINK = 8'h80
  } state_type;

  typedef enum logic [1:0] {
    MODE_HEART = 2'h1,
    MODE_MON   = 2'h2
  } mode_type;

endpackage

//--- button_debounce.sv
// button synchroniser and debouncer producing a one-cycle press pulse
`timescale 1ns/1ps
module button_debounce (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // millisecond enable
  input  wire logic i_tick,
  // raw pin, low while pressed
  input  wire logic i_button_n,
  // debounced press
  output logic      o_press
);

  logic       sync1_r, sync2_r, stable_r, stable_nxt, press_r, press_nxt;
  logic [7:0] cnt_r, cnt_nxt;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= ~i_button_n;
      sync2_r <= sync1_r;
    end
  end

  // level must hold for the debounce time before it is accepted
  always_comb begin
    stable_nxt = stable_r;
    cnt_nxt    = cnt_r;
    press_nxt  = 1'b0;
    if (sync2_r == stable_r) begin
      cnt_nxt = 8'h00;
    end else if (i_tick) begin
      if (cnt_r == 8'(tag_monitor_pkg::DEBOUNCE_MS - 1)) begin
        stable_nxt = sync2_r;
        press_nxt  = sync2_r;
        cnt_nxt    = 8'h00;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      stable_r <= 1'b0;
      cnt_r    <= 8'h00;
      press_r  <= 1'b0;
    end else begin
      stable_r <= stable_nxt;
      cnt_r    <= cnt_nxt;
      press_r  <= press_nxt;
    end
  end

  assign o_press = press_r;

endmodule

//--- gateway_model.sv
// gateway model: accepts messages, then programs and closes the window
`timescale 1ns/1ps
module gateway_model (
  // clock
  input  wire logic        i_clock,
  // device side
  input  wire logic        i_msg_valid,
  input  wire logic        i_rx_open,
  // scenario control
  input  wire logic        i_prog_en,
  input  wire logic [15:0] i_prog_data,
  input  wire logic        i_status_en,
  // answers
  output logic             o_msg_ready,
  output logic             o_status_req,
  output logic             o_prog_valid,
  output logic [15:0]      o_prog_data,
  output logic             o_done
);
  logic [2:0] win_r = 3'h0;
  logic       asked_r = 1'b0;
  initial {o_msg_ready, o_status_req, o_prog_valid, o_done, o_prog_data} = '0;
  // slow accept, then window traffic only while open
  always @(posedge i_clock) begin
    o_msg_ready  <= i_msg_valid && !o_msg_ready;
    win_r        <= i_rx_open ? win_r + 3'h1 : 3'h0;
    o_prog_valid <= i_rx_open && i_prog_en && win_r == 3'h1;
    o_prog_data  <= (win_r == 3'h1) ? i_prog_data : ~i_prog_data;
    o_done       <= i_rx_open && win_r == 3'h3;
    // one status request per enable, alongside the programming slot
    o_status_req <= i_rx_open && i_status_en && !asked_r && win_r == 3'h1;
    asked_r      <= i_status_en && (asked_r || o_status_req);
  end
endmodule

//--- testbench.sv
// testbench for the tag state controller
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, btn_n, wake, ad, ac, tv, av, ae, bv, err, pen, rdy, sr, pv, dn;
  logic [15:0] prd, pd, adat;
  logic [15:0] cells [4];
  logic [31:0] pa, pb;
  logic [7:0]  bl;
  logic        mv, ro, as, ads, bs, led, rp, fp, sen, rad;
  logic [15:0] iv, md, wt;
  logic [2:0]  mt;
  logic [1:0]  ch;
  logic [7:0]  obl, pg;
  logic [63:0] tid;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int msgs = 0;
  tag_state_ctrl #(.TICK_CYCLES(4), .PAIR_TIMEOUT_TICKS(20)) dut_u (
    .i_clock(clk), .i_nrst(nrst), .i_button_n(btn_n), .i_wake_expired(wake),
    .o_interval(iv), .o_asleep(as), .o_assoc_req(rp), .i_assoc_done(ad),
    .i_activate_done(ac), .o_msg_valid(mv), .i_msg_ready(rdy), .o_msg_type(mt),
    .o_msg_data(md), .o_rx_open(ro), .i_gw_status_req(sr), .i_gw_prog_valid(pv),
    .i_gw_prog_data(pd), .i_gw_done(dn), .o_rfid_start(), .o_rfid_page(pg),
    .i_tag_valid(tv), .i_tag_page_a(pa), .i_tag_page_b(pb), .o_tag_id(tid),
    .o_adc_start(ads), .o_adc_chan(ch), .i_adc_valid(av), .i_adc_error(ae),
    .i_adc_data(adat), .o_weight(wt), .o_batt_start(bs), .i_batt_valid(bv),
    .i_batt_level(bl), .o_batt_level(obl), .o_led(led), .o_radio_pwr(rad),
    .o_rfid_pwr(fp), .o_adc_pwr(), .o_batt_pwr());
  gateway_model gw_u (.i_clock(clk), .i_msg_valid(mv), .i_rx_open(ro), .i_prog_en(pen),
    .i_prog_data(prd), .i_status_en(sen), .o_msg_ready(rdy), .o_status_req(sr),
    .o_prog_valid(pv),
    .o_prog_data(pd), .o_done(dn));
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // battery and load-cell converters answer one cycle after start
  always @(posedge clk) begin
    bv   <= bs;
    av   <= ads;
    ae   <= ads && err && ch == 2'h2;
    adat <= cells[ch];
    cyc  <= cyc + 1;
    if (mv && rdy) msgs <= msgs + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // button held low long enough to pass the debouncer
  task automatic press();
    btn_n <= 1'b0;
    repeat (60) @(posedge clk);
    btn_n <= 1'b1;
  endtask
  // one wake: message type and data, then back asleep
  task automatic mon(input logic [2:0] t, input logic [15:0] d);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    @(posedge clk iff mv);
    #1;
    chk(64'(mt), 64'(t));
    chk(64'(md), 64'(d));
    chk(64'(rad), 64'h1);
    @(posedge clk iff as);
    #1 chk(64'(rad), 64'h0);
  endtask
  task automatic pair_ok();
    bl <= 8'h80;
    press();
    @(posedge clk iff led);
    #1 chk(64'(fp), 64'h1);
    chk(64'(pg), 64'h04);
    @(posedge clk) tv <= 1'b1;
    @(posedge clk) tv <= 1'b0;
    #1 chk(tid, 64'h1122334455667788);
    chk(64'(led), 64'h0);
    @(posedge clk iff led);
    @(posedge clk iff as);
    #1 chk(64'(led), 64'h0);
  endtask
  // pairing with no tag offered: times out dark, stored tag kept
  task automatic pair_fail(input logic [63:0] t);
    bl <= 8'h80;
    press();
    @(posedge clk iff led);
    @(posedge clk iff !led);
    #1 chk(64'(as), 64'h1);
    chk(tid, t);
  endtask
  // wake in monitor heartbeat with unchanged weight: measured, not reported
  task automatic quiet();
    int n;
    n = msgs;
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    @(posedge clk iff ads);
    @(posedge clk iff as);
    #1 chk(64'(msgs - n), 64'h0);
  endtask
  // heartbeat wake with a gateway status request in its window
  task automatic stat_hb(input logic [15:0] d);
    sen <= 1'b1;
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    @(posedge clk iff mv);
    #1 chk(64'(mt), 64'(tag_monitor_pkg::MSG_HEARTBEAT));
    @(posedge clk iff !mv);
    @(posedge clk iff mv);
    #1 chk(64'(mt), 64'(tag_monitor_pkg::MSG_STATUS));
    chk(64'(md), 64'(d));
    sen <= 1'b0;
    @(posedge clk iff as);
  endtask
  initial begin
    {wake, ad, ac, tv, err, pen, sen} = '0;
    {nrst, btn_n} = 2'b01;
    {pa, pb, bl, prd} = {32'h11223344, 32'h55667788, 8'h55, 16'h0123};
    cells = '{16'h0010, 16'h0020, 16'h0030, 16'h0040};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk) {ad, ac} <= 2'b11;
    #1 chk(64'({rp, iv}), 64'h1003C);
    @(posedge clk) {ad, ac} <= 2'b00;
    @(posedge clk);
    #1 chk(64'(as), 64'h1);
    mon(tag_monitor_pkg::MSG_HEARTBEAT, 16'h0055);
    chk(64'(obl), 64'h55);
    bl <= 8'h3F;
    press();
    repeat (60) @(posedge clk);
    #1 chk(64'({led, as}), 64'h1);
    pair_fail(64'h0);
    pair_ok();
    pen <= 1'b1;
    mon(tag_monitor_pkg::MSG_FULLNESS, 16'h00A0);
    chk(64'(iv), 64'h0123);
    chk(64'(wt), 64'h00A0);
    repeat (7) mon(tag_monitor_pkg::MSG_FULLNESS, 16'h00A0);
    mon(tag_monitor_pkg::MSG_MON_HB, 16'h00A0);
    quiet();
    pair_fail(64'h1122334455667788);
    err <= 1'b1;
    mon(tag_monitor_pkg::MSG_FULLNESS, tag_monitor_pkg::WEIGHT_ERROR);
    chk(64'(wt), 64'(tag_monitor_pkg::WEIGHT_ERROR));
    err <= 1'b0;
    cells <= '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    mon(tag_monitor_pkg::MSG_EMPTY, 16'h0000);
    stat_hb(16'h0080);
    finish_test();
  end
endmodule
